// [hdl/pwl_pkg.sv]
// pwl_pkg: register indices, reset values and answer codes of the lock
// assumes a 16-bit word register port indexed by register number
package pwl_pkg;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [15:0] PWL_ADMIN_PW_HI  = 16'h1388;
  localparam logic [15:0] PWL_ADMIN_PW_LO  = 16'h1389;
  localparam logic [15:0] PWL_ADMIN_LG_HI  = 16'h138A;
  localparam logic [15:0] PWL_ADMIN_LG_LO  = 16'h138B;
  localparam logic [15:0] PWL_USB_PW_HI    = 16'h138C;
  localparam logic [15:0] PWL_USB_PW_LO    = 16'h138D;
  localparam logic [15:0] PWL_USB_LG_HI    = 16'h138E;
  localparam logic [15:0] PWL_USB_LG_LO    = 16'h138F;
  localparam logic [15:0] PWL_RUN_LOCK_DIS = 16'h1390;
  localparam logic [15:0] PWL_RUN_LOCK_ST  = 16'h1391;
  localparam logic [15:0] PWL_ADMIN_ACT    = 16'h1392;
  localparam logic [15:0] PWL_USB_ACT      = 16'h1393;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] PWL_PW_RESET     = 16'h0000;
  localparam logic        PWL_RLD_RESET    = 1'b0;

  // ---------------------------------------------------------------
  // answer codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PWL_RSP_OK     = 2'b00,
    PWL_RSP_LOCKED = 2'b01,
    PWL_RSP_ILLEGAL = 2'b10
  } pwl_rsp_e;

endpackage : pwl_pkg

// [hdl/pwl_parameter_write_lock.sv]
// pwl_parameter_write_lock: write gate for configuration parameters
// assumes protocol front ends present one request per cycle, synchronous
//
// Contract
// [RULE_01] admin password blocks config writes, reads allowed
// [RULE_02] admin password is 32 bits at 5000/5001
// [RULE_03] login compares exact bits, notation matters
// [RULE_04] master writes admin login to 5002/5003
// [RULE_05] 5010 reads one when admin password active
// [RULE_06] zero admin password means none; zeros clear
// [RULE_07] set password storage writable only after login
// [RULE_08] factory reset clears passwords and all parameters
// [RULE_09] power-up factory state has no admin lock
// [RULE_10] usb password blocks usb config writes only
// [RULE_11] usb password at 5004/5005, zero means none
// [RULE_12] master writes usb login to 5006/5007
// [RULE_13] 5011 reads one when usb password active
// [RULE_14] after usb login zeros clear usb password
// [RULE_15] run lock makes config read-only while running
// [RULE_16] run lock enabled in factory default
// [RULE_17] 5008 one disables run lock, zero enables
// [RULE_18] 5009 reads one while run lock enabled
// [RULE_19] admin and run locks gate web writes
// [RULE_20] refused write unchanged, answered with error
module pwl_parameter_write_lock
  import pwl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        factory_reset,
  input  wire logic        motor_running,
  input  wire logic        run_command,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_usb,
  input  wire logic        req_web,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             rsp_valid,
  output pwl_rsp_e         rsp_code,
  output logic      [15:0] rsp_rdata,
  output logic             cfg_wr_en,
  output logic      [15:0] cfg_wr_addr,
  output logic      [15:0] cfg_wr_data,
  output logic             factory_restore,
  output logic             admin_active,
  output logic             usb_active,
  output logic             run_lock_on
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] admin_pw;
    logic [15:0] admin_lg_hi;
    logic        admin_ok;
    logic [31:0] usb_pw;
    logic [15:0] usb_lg_hi;
    logic        usb_ok;
    logic        run_lock_dis;
    logic        rsp_valid;
    pwl_rsp_e    rsp_code;
    logic [15:0] rsp_rdata;
    logic        cfg_wr_en;
    logic [15:0] cfg_wr_addr;
    logic [15:0] cfg_wr_data;
    logic        factory_restore;
  } pwl_state_s;

  pwl_state_s st_reg;
  pwl_state_s st_next;

  logic admin_on;
  logic usb_on;
  logic run_locked;
  logic in_block;
  logic login_reg;
  logic lock_hit;

  // ---------------------------------------------------------------
  // lock status
  // ---------------------------------------------------------------
  assign admin_on   = (st_reg.admin_pw != 32'h0000_0000); // RULE_06
  assign usb_on     = (st_reg.usb_pw != 32'h0000_0000); // RULE_11
  assign run_locked = !st_reg.run_lock_dis
                      && (motor_running || run_command); // RULE_15
  assign in_block   = (req_addr >= PWL_ADMIN_PW_HI)
                      && (req_addr <= PWL_USB_ACT);
  assign login_reg  = (req_addr == PWL_ADMIN_LG_HI)
                      || (req_addr == PWL_ADMIN_LG_LO)
                      || (req_addr == PWL_USB_LG_HI)
                      || (req_addr == PWL_USB_LG_LO);

  // login registers stay writable so a locked master can log in
  always_comb begin
    lock_hit = 1'b0;
    if (!login_reg) begin
      if (admin_on && !st_reg.admin_ok) begin
        lock_hit = 1'b1; // RULE_01 RULE_07 RULE_19
      end
      if (req_usb && usb_on && !st_reg.usb_ok) begin
        lock_hit = 1'b1; // RULE_10
      end
      if (usb_on && !st_reg.usb_ok
          && ((req_addr == PWL_USB_PW_HI)
              || (req_addr == PWL_USB_PW_LO))) begin
        lock_hit = 1'b1; // RULE_07
      end
      if (run_locked && !in_block) begin
        lock_hit = 1'b1; // RULE_15 RULE_19
      end
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next                 = st_reg;
    st_next.rsp_valid       = 1'b0;
    st_next.cfg_wr_en       = 1'b0;
    st_next.factory_restore = 1'b0;
    if (factory_reset) begin
      st_next.admin_pw        = {PWL_PW_RESET, PWL_PW_RESET}; // RULE_08
      st_next.usb_pw          = {PWL_PW_RESET, PWL_PW_RESET}; // RULE_08
      st_next.admin_ok        = 1'b0;
      st_next.usb_ok          = 1'b0;
      st_next.run_lock_dis    = PWL_RLD_RESET; // RULE_16
      st_next.factory_restore = 1'b1; // RULE_08
    end else if (req_valid) begin
      st_next.rsp_valid = 1'b1;
      st_next.rsp_code  = PWL_RSP_OK;
      st_next.rsp_rdata = 16'h0000;
      if (!req_write) begin
        unique case (req_addr)
          PWL_ADMIN_PW_HI:  st_next.rsp_rdata = st_reg.admin_pw[31:16];
          PWL_ADMIN_PW_LO:  st_next.rsp_rdata = st_reg.admin_pw[15:0];
          PWL_USB_PW_HI:    st_next.rsp_rdata = st_reg.usb_pw[31:16];
          PWL_USB_PW_LO:    st_next.rsp_rdata = st_reg.usb_pw[15:0];
          PWL_RUN_LOCK_DIS: st_next.rsp_rdata = {15'h0000,
                                                 st_reg.run_lock_dis};
          PWL_RUN_LOCK_ST:  st_next.rsp_rdata = {15'h0000,
                                                 !st_reg.run_lock_dis}; // RULE_18
          PWL_ADMIN_ACT:    st_next.rsp_rdata = {15'h0000,
                                                 admin_on}; // RULE_05 RULE_09
          PWL_USB_ACT:      st_next.rsp_rdata = {15'h0000,
                                                 usb_on}; // RULE_13
          default:          st_next.rsp_rdata = 16'h0000;
        endcase
      end else if (lock_hit) begin
        st_next.rsp_code = PWL_RSP_LOCKED; // RULE_20
      end else begin
        unique case (req_addr)
          PWL_ADMIN_PW_HI: st_next.admin_pw[31:16] = req_wdata; // RULE_02
          PWL_ADMIN_PW_LO: st_next.admin_pw[15:0]  = req_wdata; // RULE_02
          PWL_ADMIN_LG_HI: st_next.admin_lg_hi     = req_wdata; // RULE_04
          PWL_ADMIN_LG_LO: begin
            st_next.admin_ok = ({st_reg.admin_lg_hi, req_wdata}
                                == st_reg.admin_pw); // RULE_03
          end
          PWL_USB_PW_HI:   st_next.usb_pw[31:16] = req_wdata; // RULE_11
          PWL_USB_PW_LO:   st_next.usb_pw[15:0]  = req_wdata; // RULE_14
          PWL_USB_LG_HI:   st_next.usb_lg_hi     = req_wdata; // RULE_12
          PWL_USB_LG_LO: begin
            st_next.usb_ok = ({st_reg.usb_lg_hi, req_wdata}
                              == st_reg.usb_pw); // RULE_03
          end
          PWL_RUN_LOCK_DIS: st_next.run_lock_dis = req_wdata[0]; // RULE_17
          PWL_RUN_LOCK_ST, PWL_ADMIN_ACT, PWL_USB_ACT: begin
            st_next.rsp_code = PWL_RSP_ILLEGAL;
          end
          default: begin
            st_next.cfg_wr_en   = 1'b1;
            st_next.cfg_wr_addr = req_addr;
            st_next.cfg_wr_data = req_wdata;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg.admin_pw        <= {PWL_PW_RESET, PWL_PW_RESET}; // RULE_09
      st_reg.admin_lg_hi     <= 16'h0000;
      st_reg.admin_ok        <= 1'b0;
      st_reg.usb_pw          <= {PWL_PW_RESET, PWL_PW_RESET};
      st_reg.usb_lg_hi       <= 16'h0000;
      st_reg.usb_ok          <= 1'b0;
      st_reg.run_lock_dis    <= PWL_RLD_RESET; // RULE_16
      st_reg.rsp_valid       <= 1'b0;
      st_reg.rsp_code        <= PWL_RSP_OK;
      st_reg.rsp_rdata       <= 16'h0000;
      st_reg.cfg_wr_en       <= 1'b0;
      st_reg.cfg_wr_addr     <= 16'h0000;
      st_reg.cfg_wr_data     <= 16'h0000;
      st_reg.factory_restore <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rsp_valid       = st_reg.rsp_valid;
  assign rsp_code        = st_reg.rsp_code;
  assign rsp_rdata       = st_reg.rsp_rdata;
  assign cfg_wr_en       = st_reg.cfg_wr_en;
  assign cfg_wr_addr     = st_reg.cfg_wr_addr;
  assign cfg_wr_data     = st_reg.cfg_wr_data;
  assign factory_restore = st_reg.factory_restore;
  assign admin_active    = admin_on;
  assign usb_active      = usb_on;
  assign run_lock_on     = !st_reg.run_lock_dis;

endmodule : pwl_parameter_write_lock

// [verif/pwl_write_lock_props.sv]
// pwl_write_lock_props: port checker for the write lock
// assumes it is bound onto pwl_parameter_write_lock
module pwl_write_lock_props
  import pwl_pkg::*;
(
  input wire logic        clk, rst, factory_reset, motor_running,
  input wire logic        run_command, req_valid, req_write,
  input wire logic        req_usb, req_web, rsp_valid, cfg_wr_en,
  input wire logic        factory_restore, admin_active, usb_active,
  input wire logic        run_lock_on,
  input wire logic [15:0] req_addr, req_wdata, rsp_rdata,
  input wire logic [15:0] cfg_wr_addr, cfg_wr_data,
  input wire pwl_rsp_e    rsp_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire tk  = req_valid && !factory_reset;
  wire wr  = tk && req_write;
  wire rd  = tk && !req_write;
  wire cfg = req_addr < 16'h1388 || req_addr > 16'h1393;
  chk_answer_once:
    assert property (rsp_valid == $past(tk)) else $error("answer");
  chk_run_lock:
    assert property (wr && cfg && run_lock_on && (motor_running ||
      run_command) |=> rsp_code == PWL_RSP_LOCKED && !cfg_wr_en)
      else $error("run lock");
  chk_status_ro:
    assert property (wr && req_addr inside {[16'h1391:16'h1393]}
      && !admin_active && !(req_usb && usb_active) |=>
      rsp_code == PWL_RSP_ILLEGAL && !cfg_wr_en) else $error("status");
  chk_read_free:
    assert property (rd |=> rsp_code == PWL_RSP_OK && !cfg_wr_en)
      else $error("read");
  chk_wr_echo:
    assert property (cfg_wr_en |-> $past(wr && cfg) && cfg_wr_addr ==
      $past(req_addr) && cfg_wr_data == $past(req_wdata)) else $error("wr");
  chk_factory_clr:
    assert property (factory_reset |=> factory_restore && !admin_active
      && !usb_active && run_lock_on) else $error("factory");
  chk_admin_flag:
    assert property (rd && req_addr == 16'h1392 |=>
      rsp_rdata == {15'h0000, $past(admin_active)}) else $error("admin");
  chk_run_flag:
    assert property (rd && req_addr == 16'h1391 |=>
      rsp_rdata == {15'h0000, $past(run_lock_on)}) else $error("runflag");
  cover property (rsp_valid && rsp_code == PWL_RSP_LOCKED);
  cover property (cfg_wr_en);
  cover property (factory_restore);
endmodule : pwl_write_lock_props

bind pwl_parameter_write_lock pwl_write_lock_props u_props (.*);

// [verif/pwl_master_model.sv]
// pwl_master_model: fieldbus master, one request at a time
// assumes the answer lands on the taking edge itself, read half a cycle later
module pwl_master_model (
  input  wire logic clk,
  output logic      req_valid, req_write, req_usb, req_web,
  output logic      motor_running, run_command,
  output logic [15:0] req_addr, req_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {req_valid, req_write, req_usb, req_web} = 4'h0;
    {motor_running, run_command} = 2'h0;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
  end
  // held over the taking edge, released with lines flipped
  task automatic xfer(input logic [3:0] f, input logic w,
                      input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    {req_web, req_usb, run_command, motor_running} = f;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    req_addr = ~a;
    req_wdata = ~d;
  endtask : xfer
endmodule : pwl_master_model

// [verif/tb_parameter_write_lock.sv]
// tb_parameter_write_lock: table driven bench of the write lock
// assumes the master model drives every request input
module tb_parameter_write_lock;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, factory_reset, req_valid, req_write, req_usb, req_web;
  logic motor_running, run_command, rsp_valid, cfg_wr_en, factory_restore;
  logic admin_active, usb_active, run_lock_on;
  logic [15:0] req_addr, req_wdata, rsp_rdata, cfg_wr_addr, cfg_wr_data;
  pwl_pkg::pwl_rsp_e rsp_code;
  int miscompares = 0;
  int checked = 0;
  // flags web,usb,run_cmd,motor | write | addr | data | code | rdata
  localparam logic [59:0] ROWS [31] = '{
    60'h0_0_1392_0000_0_0000, 60'h0_0_1391_0000_0_0001,
    60'h8_1_2000_0005_0_0000, 60'h0_1_1392_0001_2_0000,
    60'h0_1_1388_1234_0_0000, 60'h0_1_1389_5678_1_0000,
    60'h0_0_1392_0000_0_0001, 60'h8_1_2000_0007_1_0000,
    60'h0_0_2000_0000_0_0000, 60'h0_1_1388_0000_1_0000,
    60'h0_1_138A_1234_0_0000, 60'h0_1_138B_5679_0_0000,
    60'h0_1_2000_0008_1_0000, 60'h0_1_138A_1234_0_0000,
    60'h0_1_138B_0000_0_0000, 60'h0_1_2000_0009_0_0000,
    60'h0_1_1388_0000_0_0000, 60'h0_1_1389_0000_0_0000,
    60'h0_0_1392_0000_0_0000, 60'h0_1_138C_ABCD_0_0000,
    60'h0_1_138D_0001_1_0000, 60'h0_0_1393_0000_0_0001,
    60'h4_1_2000_000A_1_0000, 60'h4_1_138E_ABCD_0_0000,
    60'h4_1_138F_0000_0_0000, 60'h4_1_138C_0000_0_0000,
    60'h4_1_138D_0000_0_0000, 60'h1_1_2000_000D_1_0000,
    60'h1_1_1390_0001_0_0000, 60'h3_1_2000_000F_0_0000,
    60'h2_1_1391_0000_2_0000};
  pwl_parameter_write_lock DUT (.*);
  pwl_master_model m (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic test_done;
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      $display("BAD %0t %h %h", $time, g, e);
      miscompares++;
    end
  endtask : chk
  task automatic go(input logic [59:0] r);
    logic ok;
    ok = r[52] && r[19:16] == 4'h0 &&
         (r[51:36] < 16'h1388 || r[51:36] > 16'h1393);
    m.xfer(r[59:56], r[52], r[51:36], r[35:20]);
    chk({15'h0000, rsp_valid}, 16'h0001);
    chk({14'h0000, rsp_code}, {12'h000, r[19:16]});
    chk(rsp_rdata, r[15:0]);
    chk({15'h0000, cfg_wr_en}, {15'h0000, ok});
    if (ok) chk(cfg_wr_data, r[35:20]);
    if (ok) chk(cfg_wr_addr, r[51:36]);
  endtask : go
  initial begin
    #20000;
    miscompares++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    factory_reset = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    foreach (ROWS[i]) go(ROWS[i]);
    m.xfer(4'h0, 1'b1, 16'h138C, 16'h0001);
    factory_reset = 1'b1;
    m.xfer(4'h0, 1'b1, 16'h2000, 16'h0001);
    factory_reset = 1'b0;
    chk({15'h0000, rsp_valid}, 16'h0000);
    chk({15'h0000, factory_restore}, 16'h0001);
    chk({14'h0000, usb_active, run_lock_on}, 16'h0001);
    m.xfer(4'h0, 1'b1, 16'h1388, 16'h00FF);
    rst = 1'b1;
    @(negedge clk);
    chk({14'h0000, admin_active, run_lock_on}, 16'h0001);
    rst = 1'b0;
    test_done();
  end
endmodule : tb_parameter_write_lock
